// ==== design/bbs_defines.svh ====
// Timing and width constants for the buck-boost switch sequencer
`ifndef BBS_DEFINES_SVH
`define BBS_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and rounding helpers
// ----------------------------------------------------------------
`define BBS_CLK_NS          20
`define BBS_CYC_UP(ns)      (((ns) + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_CYC_DN(ns)      ((ns) / `BBS_CLK_NS)

// ----------------------------------------------------------------
// Times in ns and their cycle counts
// ----------------------------------------------------------------
`define BBS_PERIOD_NS       2000
`define BBS_PERIOD_CYC      `BBS_CYC_DN(`BBS_PERIOD_NS)
`define BBS_DEAD_NS         30
`define BBS_DEAD_CYC        `BBS_CYC_UP(`BBS_DEAD_NS)
`define BBS_MIN_ON_NS       100
`define BBS_MIN_ON_CYC      `BBS_CYC_UP(`BBS_MIN_ON_NS)
`define BBS_MIN_OFF_NS      100
`define BBS_MIN_OFF_CYC     `BBS_CYC_UP(`BBS_MIN_OFF_NS)
`define BBS_S1_MAX_CYC      (`BBS_PERIOD_CYC - `BBS_MIN_OFF_CYC)
`define BBS_BB_S2_NS        400
`define BBS_BB_S2_CYC       `BBS_CYC_UP(`BBS_BB_S2_NS)
`define BBS_SP1_NS          200
`define BBS_SP1_CYC         `BBS_CYC_UP(`BBS_SP1_NS)
`define BBS_SP2_NS          200
`define BBS_SP2_CYC         `BBS_CYC_UP(`BBS_SP2_NS)
`define BBS_SP3_NS          400
`define BBS_SP3_CYC         `BBS_CYC_UP(`BBS_SP3_NS)
`define BBS_WAKE_NS         2000
`define BBS_WAKE_CYC        `BBS_CYC_UP(`BBS_WAKE_NS)

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define BBS_CNT_W           8
`define BBS_VOLT_W          12
`define BBS_DEAD_W          3

`endif

// ==== design/bbs_pkg.sv ====
// Types shared by the buck-boost switch sequencer
`default_nettype none

package bbs_pkg;

  // ----------------------------------------------------------------
  // Sequencer states, Gray along S1 -> S2 -> S3
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_OFF   = 3'h0,
    SEQ_S1    = 3'h1,
    SEQ_S2    = 3'h3,
    SEQ_S3    = 3'h2,
    SEQ_PASS  = 3'h6,
    SEQ_PAUSE = 3'h7,
    SEQ_SLEEP = 3'h5
  } bbs_state_t;

  // Conversion operation in force
  typedef enum logic [1:0] {
    OP_BUCK  = 2'h0,
    OP_BOOST = 2'h1,
    OP_BB    = 2'h3
  } bbs_op_t;

  // Four gate commands, one bit per switch
  typedef struct packed {
    logic input_high_switch;
    logic input_low_switch;
    logic output_low_switch;
    logic output_high_switch;
  } bbs_gates_t;

  // Comparator and regulation loop inputs
  typedef struct packed {
    logic peak;       // Inductor current at peak
    logic psm_entry;  // Current at power-save entry level
    logic light;      // Load lighter still
    logic vout_high;  // Loop sees output rise
    logic vout_low;   // Output back at set point
    logic win_in;     // Input inside conduction window
    logic acm_up;     // Loop asks for a state one pulse
    logic acm_down;   // Loop asks for a state three pulse
  } bbs_cmp_t;

endpackage

`default_nettype wire

// ==== design/bbs_seq.sv ====
// Four-switch buck-boost sequencer with power-save and conduction window
//
// Notes on behaviour
// - State one: input high, output low on
// - State two: both high switches on
// - State three: input low, output high on
// - Buck cycle starts in state two
// - Buck peak current moves two to three
// - Next clock pulse returns buck to two
// - Buck holds while off-time meets minimum
// - Boost cycle starts in state one
// - Boost goes one to two after sampling
// - Boost duty capped by minimum off-time
// - Short on or off-time selects buck-boost
// - Buck-boost runs one, two, three
// - Mode pin low enables power save
// - Below entry level, timed single pulses
// - Lighter load: pulses at quarter rate
// - Output rise stops: pause or sleep
// - Sleep holds lows on, timed wake
// - Automatic conduction dwells in state two
// - Inside window both high switches on
// - Window only after soft-start done
// - Window keeps current limit, bias off in power save
// - Window bounds from target and hysteresis
`default_nettype none
`include "bbs_defines.svh"

module bbs_seq
  import bbs_pkg::*;
(
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   run_i,
  input  wire logic                   mode_sel_i,
  input  wire logic                   sleep_en_i,
  input  wire logic                   pcm_en_i,
  input  wire logic                   softstart_done_i,
  input  wire logic                   vin_above_vout_i,
  input  wire logic                   buck_off_short_i,
  input  wire logic                   boost_on_short_i,
  input  wire bbs_cmp_t               cmp_i,
  input  wire logic [`BBS_VOLT_W-1:0] vout_target_i,
  input  wire logic [`BBS_VOLT_W-1:0] win_low_hyst_i,
  output var  bbs_gates_t             gates_o,
  output var  bbs_state_t             state_o,
  output var  bbs_op_t                op_mode_o,
  output var  logic                   deep_sleep_o,
  output var  logic                   bias_off_o,
  output var  logic [`BBS_VOLT_W-1:0] win_upper_o,
  output var  logic [`BBS_VOLT_W-1:0] win_lower_o
);

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------

  // Gate pattern of each state
  function automatic bbs_gates_t gates_of(input bbs_state_t s);
    bbs_gates_t g;
    g = '0;
    case (s)
      SEQ_S1:    g = 4'hA;
      SEQ_S2:    g = 4'h9;
      SEQ_S3:    g = 4'h5;
      SEQ_PASS:  g = 4'h9;
      SEQ_SLEEP: g = 4'h6;
      default:   g = 4'h0;
    endcase
    return g;
  endfunction

  // First state of a fresh switching cycle
  function automatic bbs_state_t start_of(input bbs_op_t m, input logic pass);
    bbs_state_t s;
    if (pass)
      s = SEQ_PASS;
    else if (m == OP_BUCK)
      s = SEQ_S2;
    else
      s = SEQ_S1;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Comparator synchronisation
  // ----------------------------------------------------------------
  bbs_cmp_t c_s;  // Synchronised comparator bundle

  bbs_sync #(
    .W ($bits(bbs_cmp_t))
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        (cmp_i),
    .q_o        (c_s)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  bbs_state_t             st_q;     // Sequencer state
  bbs_state_t             st_d;
  logic                   acm_q;    // Current S1 or S3 is a short pulse
  logic                   acm_d;
  logic [`BBS_CNT_W-1:0]  cnt_q;    // Cycles spent in this state
  logic [`BBS_CNT_W-1:0]  per_q;    // Switching period divider
  logic                   pulse_q;  // Internal clock pulse
  logic [1:0]             qtr_q;    // Divides pulses by four
  bbs_op_t                op_q;     // Operation in force
  logic [`BBS_DEAD_W-1:0] dt_q;     // Dead interval countdown

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire psm_on   = ~mode_sel_i;
  wire sp_act   = psm_on & c_s.psm_entry;
  wire acm_act  = psm_on & ~c_s.psm_entry & (op_q == OP_BB);
  wire pass_ok  = pcm_en_i & softstart_done_i & c_s.win_in;
  wire sleep_go = sp_act & c_s.vout_high;
  wire sp_start = pulse_q & (~c_s.light | (qtr_q == 2'h0));
  wire go_start = sp_act ? sp_start : pulse_q;

  // Buck-boost when either timer limit is hit, else by input level
  wire bb_need  = boost_on_short_i | buck_off_short_i;
  wire bbs_op_t op_d = bb_need ? OP_BB :
                       vin_above_vout_i ? OP_BUCK : OP_BOOST;

  // Count thresholds
  wire min_on_ok = cnt_q >= `BBS_CNT_W'(`BBS_MIN_ON_CYC);
  wire s1_max    = cnt_q >= `BBS_CNT_W'(`BBS_S1_MAX_CYC);
  wire sp1_done  = cnt_q >= `BBS_CNT_W'(`BBS_SP1_CYC);
  wire sp2_done  = cnt_q >= `BBS_CNT_W'(`BBS_SP2_CYC);
  wire sp3_done  = cnt_q >= `BBS_CNT_W'(`BBS_SP3_CYC);
  wire bb2_done  = cnt_q >= `BBS_CNT_W'(`BBS_BB_S2_CYC);
  wire wake_done = cnt_q >= `BBS_CNT_W'(`BBS_WAKE_CYC);

  // Peak is sampled at the end of state one, bounded by duty cap
  wire s1_done = acm_q  ? min_on_ok :
                 sp_act ? sp1_done :
                 ((c_s.peak & min_on_ok) | s1_max);

  // ----------------------------------------------------------------
  // Switching clock divider
  // ----------------------------------------------------------------

  // One-cycle pulse per switching period, plus quarter counter
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      per_q   <= '0;
      pulse_q <= 1'b0;
      qtr_q   <= 2'h0;
    end
    else
    begin
      pulse_q <= (per_q == `BBS_CNT_W'(`BBS_PERIOD_CYC - 1));
      per_q   <= (per_q == `BBS_CNT_W'(`BBS_PERIOD_CYC - 1)) ? '0 : per_q + 1'b1;
      if (pulse_q)
        qtr_q <= qtr_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Transitions of the switching state machine
  always_comb
  begin
    st_d  = st_q;
    acm_d = acm_q;
    if (!run_i)
    begin
      // Stopped: all switches off
      st_d  = SEQ_OFF;
      acm_d = 1'b0;
    end
    else
    begin
      case (st_q)
        SEQ_OFF:
        begin
          acm_d = 1'b0;
          if (sleep_go)
            st_d = sleep_en_i ? SEQ_SLEEP : SEQ_PAUSE;
          else if (pass_ok)
            st_d = SEQ_PASS;
          else if (go_start)
            st_d = sp_act ? SEQ_S1 : start_of(op_q, 1'b0);
        end
        SEQ_S1:
        begin
          // Magnetisation for boost, buck-boost and power-save single pulses
          if (s1_done)
          begin
            st_d  = SEQ_S2;
            acm_d = 1'b0;
          end
        end
        SEQ_S2:
        begin
          if (acm_act && !sp_act)
          begin
            // Dwell here; short pulses only on demand
            if (pulse_q && c_s.acm_up)
            begin
              st_d  = SEQ_S1;
              acm_d = 1'b1;
            end
            else if (pulse_q && c_s.acm_down)
            begin
              st_d  = SEQ_S3;
              acm_d = 1'b1;
            end
          end
          else if (sp_act)
          begin
            if (sp2_done)
              st_d = SEQ_S3;
          end
          else if (op_q == OP_BUCK)
          begin
            if (c_s.peak)
              st_d = SEQ_S3;
          end
          else if (op_q == OP_BOOST)
          begin
            if (pulse_q)
              st_d = start_of(op_q, pass_ok);
          end
          else if (bb2_done)
            st_d = SEQ_S3;
        end
        SEQ_S3:
        begin
          if (acm_q)
          begin
            // Minimum-length demagnetisation pulse
            if (min_on_ok)
            begin
              st_d  = SEQ_S2;
              acm_d = 1'b0;
            end
          end
          else if (sp_act)
          begin
            if (sp3_done)
              st_d = SEQ_OFF;
          end
          else if (pulse_q)
            st_d = start_of(op_q, pass_ok);
        end
        SEQ_PASS:
        begin
          // Window exit or peak limit ends the pass-through
          if (!pass_ok)
            st_d = SEQ_OFF;
          else if (c_s.peak)
            st_d = SEQ_S3;
        end
        SEQ_PAUSE:
        begin
          if (c_s.vout_low)
            st_d = SEQ_OFF;
        end
        SEQ_SLEEP:
        begin
          // Wake only after the output stayed low for the wake time
          if (c_s.vout_low && wake_done)
            st_d = SEQ_OFF;
        end
        default:
        begin
          st_d = SEQ_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------

  // State, dwell counter and operation
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q  <= SEQ_OFF;
      acm_q <= 1'b0;
      cnt_q <= '0;
      op_q  <= OP_BUCK;
    end
    else
    begin
      st_q  <= st_d;
      acm_q <= acm_d;
      op_q  <= op_d;
      if (st_d != st_q || (st_q == SEQ_SLEEP && !c_s.vout_low))
        cnt_q <= '0;
      else if (cnt_q != '1)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Gate drive with dead interval
  // ----------------------------------------------------------------
  wire bbs_gates_t tgt = gates_of(st_q);
  wire bbs_gates_t cut = gates_o & ~tgt;  // Switches to be turned off

  // Switches only turning on move at once; any turn-off first leaves
  // the common part, so a leg never swaps inside one cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gates_o <= '0;
      dt_q    <= '0;
    end
    else if (dt_q != '0)
      dt_q <= dt_q - 1'b1;
    else if (gates_o != tgt)
    begin
      if (cut == '0)
        gates_o <= tgt;
      else
      begin
        gates_o <= gates_o & tgt;
        dt_q    <= `BBS_DEAD_W'(`BBS_DEAD_CYC);
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and window outputs
  // ----------------------------------------------------------------
  wire [`BBS_VOLT_W-1:0] win_lo_d = (win_low_hyst_i > vout_target_i) ? '0 :
                                    vout_target_i - win_low_hyst_i;

  // Registered status, bias control and window bounds
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_o      <= SEQ_OFF;
      op_mode_o    <= OP_BUCK;
      deep_sleep_o <= 1'b0;
      bias_off_o   <= 1'b0;
      win_upper_o  <= '0;
      win_lower_o  <= '0;
    end
    else
    begin
      state_o      <= st_q;
      op_mode_o    <= op_q;
      deep_sleep_o <= (st_q == SEQ_SLEEP);
      bias_off_o   <= (st_q == SEQ_PASS) & ~mode_sel_i;
      win_upper_o  <= vout_target_i;
      win_lower_o  <= win_lo_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  no_shoot_a: assert property (
    !(gates_o.input_high_switch && gates_o.input_low_switch) &&
    !(gates_o.output_high_switch && gates_o.output_low_switch))
    else $error("Both switches of one leg are on");

  dead_leg_a: assert property (
    $fell(gates_o.input_high_switch) |-> !gates_o.input_low_switch [*3])
    else $error("Input leg swapped without dead interval");

  state_one_a: assert property (
    (st_q == SEQ_S1 && $stable(st_q)) [*6] |-> gates_o == 4'hA)
    else $error("State one gates wrong");

  state_two_a: assert property (
    (st_q == SEQ_S2 && $stable(st_q)) [*6] |-> gates_o == 4'h9)
    else $error("State two gates wrong");

  state_three_a: assert property (
    (st_q == SEQ_S3 && $stable(st_q)) [*6] |-> gates_o == 4'h5)
    else $error("State three gates wrong");

  buck_peak_a: assert property (
    st_q == SEQ_S2 && op_q == OP_BUCK && run_i && !psm_on && c_s.peak
    |=> st_q == SEQ_S3)
    else $error("Buck peak did not end state two");

  buck_restart_a: assert property (
    st_q == SEQ_S3 && op_q == OP_BUCK && run_i && !psm_on && !acm_q
    && pulse_q && !pass_ok |=> st_q == SEQ_S2)
    else $error("Buck clock pulse did not restart state two");

  boost_start_a: assert property (
    st_q == SEQ_S2 && op_q == OP_BOOST && run_i && !psm_on && pulse_q
    && !pass_ok |=> st_q == SEQ_S1)
    else $error("Boost cycle did not start in state one");

  boost_cap_a: assert property (
    st_q == SEQ_S1 && !psm_on && !acm_q && run_i && s1_max |=> st_q == SEQ_S2)
    else $error("State one ran past its duty cap");

  // Sampled reset term keeps the release edge, where flops still reset, out of the antecedent
  bb_select_a: assert property (
    rst_n_i && bb_need |=> op_q == OP_BB)
    else $error("Timer limit did not select buck-boost");

  pass_soft_a: assert property (
    st_q == SEQ_PASS |-> $past(softstart_done_i) && pcm_en_i)
    else $error("Pass-through before soft-start done");

  sleep_lows_a: assert property (
    (st_q == SEQ_SLEEP) [*6] |-> gates_o.input_low_switch && gates_o.output_low_switch)
    else $error("Sleep does not hold both low switches on");

  win_low_a: assert property (
    rst_n_i && vout_target_i >= win_low_hyst_i |=> win_lower_o == $past(vout_target_i) - $past(win_low_hyst_i))
    else $error("Window lower bound wrong");

endmodule

`default_nettype wire

// ==== design/bbs_sync.sv ====
// Two-flop synchroniser for comparator levels
`default_nettype none

module bbs_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q;  // First stage, read by the second only

  // Both stages clear to zero under reset
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ==== verif/bbs_stage_model.sv ====
// Behavioural power stage: turns gate commands into a peak-current comparator level
`default_nettype none

module bbs_stage_model
  import bbs_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire bbs_gates_t gates_i,
  input  wire logic [7:0] ramp_len_i,
  output var  logic       peak_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Inductor current ramp
  // ----------------------------------------------------------------
  bbs_gates_t last_q;   // Gate pattern of the previous cycle
  logic [7:0] dwell_q;  // Cycles spent in one pattern, saturating
  logic       charge;   // Inductor magnetising from the input side

  assign charge = gates_i.input_high_switch && !gates_i.input_low_switch;

  // Any gate change restarts the ramp, so each state is timed on its own
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      last_q  <= '0;
      dwell_q <= 8'h00;
    end
    else
    begin
      last_q  <= gates_i;
      dwell_q <= (gates_i != last_q) ? 8'h00 : dwell_q + {7'h00, dwell_q != 8'hFF};
    end
  end

  // Trip level; a zero ramp length means the current never peaks
  assign peak_o = charge && (ramp_len_i != 8'h00) && (dwell_q >= ramp_len_i);
endmodule

`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the buck-boost switch sequencer
`default_nettype none
`include "bbs_defines.svh"

module tb_top
  import bbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic core_clk_i, rst_n_i, run_i, mode_sel_i, sleep_en_i, pcm_en_i;
  logic softstart_done_i, vin_above_vout_i, buck_off_short_i, boost_on_short_i;
  logic                   peak;       // From the stage model
  logic [7:0]             ramp_len;   // Stage model ramp length
  bbs_cmp_t               cmp_tb;     // Bench-driven comparator levels
  bbs_cmp_t               cmp_w;      // Peak merged in
  logic [`BBS_VOLT_W-1:0] tgt, hyst, win_upper_o, win_lower_o;
  bbs_gates_t             gates_o;
  bbs_state_t             state_o, prev_st;
  bbs_op_t                op_mode_o, exp_op;  // Seen and expected operation
  logic                   deep_sleep_o, bias_off_o;
  bbs_state_t             exp_q[$];   // Expected state order
  int                     errors, check_count, cyc, dwell, s1_at;

  assign cmp_w = {peak, cmp_tb[6:0]};
  // Either timer limit forces buck-boost, else the input level picks buck or boost
  assign exp_op = (buck_off_short_i | boost_on_short_i) ? OP_BB : vin_above_vout_i ? OP_BUCK : OP_BOOST;

  bbs_seq bbs_seq_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .run_i(run_i), .mode_sel_i(mode_sel_i),
    .sleep_en_i(sleep_en_i), .pcm_en_i(pcm_en_i), .softstart_done_i(softstart_done_i),
    .vin_above_vout_i(vin_above_vout_i), .buck_off_short_i(buck_off_short_i),
    .boost_on_short_i(boost_on_short_i), .cmp_i(cmp_w), .vout_target_i(tgt), .win_low_hyst_i(hyst),
    .gates_o(gates_o), .state_o(state_o), .op_mode_o(op_mode_o), .deep_sleep_o(deep_sleep_o),
    .bias_off_o(bias_off_o), .win_upper_o(win_upper_o), .win_lower_o(win_lower_o));

  bbs_stage_model bbs_stage_model_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .gates_i(gates_o),
    .ramp_len_i(ramp_len), .peak_o(peak));

  // 50 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Gate pattern each settled state must show
  function automatic logic [3:0] gate_tab(input bbs_state_t s);
    case (s)
      SEQ_S1:             return 4'hA;
      SEQ_S2, SEQ_PASS:   return 4'h9;
      SEQ_S3:             return 4'h5;
      SEQ_SLEEP:          return 4'h6;
      default:            return 4'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Output watcher, sampled on the falling edge away from updates
  // ----------------------------------------------------------------
  always @(negedge core_clk_i)
  begin
    cyc++;
    if (!rst_n_i)
    begin
      prev_st = SEQ_OFF;
      dwell   = 0;
    end
    else
    begin
      check("shoot", 16'h0, {15'h0, (gates_o[3] & gates_o[2]) | (gates_o[1] & gates_o[0])});
      check("pass_early", 16'h0, {15'h0, state_o == SEQ_PASS && !softstart_done_i});
      if (state_o !== prev_st)
      begin
        if (prev_st == SEQ_S1)
          check("s1_long", 16'h0, {15'h0, dwell > 96});
        if (state_o == SEQ_S1 && cmp_tb.light && !mode_sel_i && s1_at > 0)
          check("gap", 16'h0, {15'h0, (cyc - s1_at) < 390 || (cyc - s1_at) > 410});
        if (state_o == SEQ_S1)
          s1_at = cyc;
        if (state_o !== SEQ_OFF && exp_q.size() > 0)
          check("state", {13'h0, exp_q.pop_front()}, {13'h0, state_o});
        dwell = 0;
      end
      else
        dwell++;
      if (dwell == 6)
      begin
        check("gates", {12'h0, gate_tab(state_o)}, {12'h0, gates_o});
        check("sleep", {15'h0, state_o == SEQ_SLEEP}, {15'h0, deep_sleep_o});
        check("bias", {15'h0, state_o == SEQ_PASS && !mode_sel_i}, {15'h0, bias_off_o});
        check("op", {14'h0, exp_op}, {14'h0, op_mode_o});
      end
      prev_st = state_o;
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Reset mid-run, then apply {pcm, mode, sleep, vin_above, buck_short, boost_short}
  task automatic setup(input logic [5:0] cfg, input logic [7:0] ramp, input logic [7:0] cmp);
    rst_n_i  <= 1'b0;
    exp_q.delete();
    s1_at = 0;
    {pcm_en_i, mode_sel_i, sleep_en_i, vin_above_vout_i, buck_off_short_i, boost_on_short_i} <= cfg;
    ramp_len <= ramp;
    cmp_tb   <= cmp;
    repeat (5) @(posedge core_clk_i);
    rst_n_i  <= 1'b1;
  endtask

  task automatic push(input bbs_state_t a, b, c, d);
    if (a != SEQ_OFF) exp_q.push_back(a);
    if (b != SEQ_OFF) exp_q.push_back(b);
    if (c != SEQ_OFF) exp_q.push_back(c);
    if (d != SEQ_OFF) exp_q.push_back(d);
  endtask

  // Bounded wait for every expected state to appear
  task automatic wait_q(input int lim);
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < lim)
    begin
      @(posedge core_clk_i);
      n++;
    end
    if (exp_q.size() > 0)
    begin
      errors++;
      $display("mismatch queue expected 0 seen %0d", exp_q.size());
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n_i = 1'b0; run_i = 1'b1; softstart_done_i = 1'b1; ramp_len = 8'h00;
    {pcm_en_i, mode_sel_i, sleep_en_i, vin_above_vout_i, buck_off_short_i, boost_on_short_i} = 6'b010100;
    cmp_tb = '0; tgt = '0; hyst = '0; errors = 0; check_count = 0; cyc = 0; s1_at = 0;
    void'($urandom(23));
    setup(6'b010100, 8'h00, 8'h00);
    // Window bounds from random target and hysteresis, saturating low bound
    repeat (8)
    begin
      @(posedge core_clk_i);
      tgt  <= `BBS_VOLT_W'($urandom);
      hyst <= `BBS_VOLT_W'($urandom);
      repeat (2) @(posedge core_clk_i);
      check("upper", {4'h0, tgt}, {4'h0, win_upper_o});
      check("lower", {4'h0, (hyst > tgt) ? 12'h000 : tgt - hyst}, {4'h0, win_lower_o});
    end
    // Fixed frequency buck ignores power-save levels
    setup(6'b010100, 8'd30, 8'h60); push(SEQ_S2, SEQ_S3, SEQ_S2, SEQ_S3); wait_q(1000);
    // Boost with peak, then with the duty cap ending state one
    setup(6'b010000, 8'd30, 8'h00); push(SEQ_S1, SEQ_S2, SEQ_S1, SEQ_S2); wait_q(1000);
    setup(6'b010000, 8'h00, 8'h00); push(SEQ_S1, SEQ_S2, SEQ_S1, SEQ_S2); wait_q(1000);
    // Buck-boost from either timer limit
    setup(6'b010110, 8'd20, 8'h00); push(SEQ_S1, SEQ_S2, SEQ_S3, SEQ_S1); wait_q(1000);
    setup(6'b010001, 8'd20, 8'h00); push(SEQ_S1, SEQ_S2, SEQ_S3, SEQ_S1); wait_q(1000);
    // Light-load single pulses at a quarter of the rate
    setup(6'b000100, 8'd20, 8'h60); push(SEQ_S1, SEQ_S2, SEQ_S3, SEQ_S1); wait_q(1500);
    // Output rise: pause, then deep sleep, both woken by the set point
    for (int sl = 0; sl < 2; sl++)
    begin
      setup({2'b00, sl[0], 3'b100}, 8'd20, 8'h50);
      push(sl ? SEQ_SLEEP : SEQ_PAUSE, SEQ_OFF, SEQ_OFF, SEQ_OFF); wait_q(1000);
      cmp_tb <= 8'h48;
      push(SEQ_S1, SEQ_OFF, SEQ_OFF, SEQ_OFF); wait_q(1000);
    end
    // Automatic conduction: dwell in two, short one and three on demand
    // Entry runs one capped state one, then the sequencer settles in state two
    setup(6'b000110, 8'h00, 8'h00); push(SEQ_S1, SEQ_S2, SEQ_OFF, SEQ_OFF); wait_q(1000);
    cmp_tb <= 8'h02; push(SEQ_S1, SEQ_S2, SEQ_OFF, SEQ_OFF); wait_q(1000);
    cmp_tb <= 8'h01; push(SEQ_S3, SEQ_S2, SEQ_OFF, SEQ_OFF); wait_q(1000);
    // Conduction window held off until soft-start ends, current limit inside it
    softstart_done_i <= 1'b0;
    setup(6'b100100, 8'd30, 8'h04);
    push(SEQ_S2, SEQ_S3, SEQ_S2, SEQ_S3); wait_q(1000);
    // Released early in state three, so the next clock pulse opens the window
    softstart_done_i <= 1'b1; push(SEQ_PASS, SEQ_OFF, SEQ_OFF, SEQ_OFF); wait_q(1000);
    ramp_len <= 8'd30; push(SEQ_S3, SEQ_PASS, SEQ_OFF, SEQ_OFF); wait_q(1000);
    // Run dropped: gates settle off
    run_i <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    end_of_test();
  end
endmodule

`default_nettype wire
